// ### bench/tec16_counter_test.sv
// testbench of the timer/event counter: apb tasks and directed tests
// assumes tec16_pkg and the pin source model are compiled first
`timescale 1ns/1ps
module tec16_counter_test;
  import tec16_pkg::*;
  logic sys_clk, reset_n, pin, irq, wake, err;
  tec16_apb_req_t req;
  tec16_apb_rsp_t rsp;
  int errors, n_compared, cycles, wakes;
  logic [31:0] rd;
  logic [15:0] v, v2;
  tec16_counter DUT (.SYS_CLK_IN(sys_clk), .RESET_N_IN(reset_n), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
    .EVENT_INPUT_PIN_IN(pin), .OVERFLOW_IRQ_OUT(irq), .WAKEUP_OUT(wake));
  tec16_pin_source SRC (.clk_in(sys_clk), .pin_out(pin));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------------------
  // watchdog and wake-up pulse count
  // --------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // --------------------------------------------------------------
  // apb master tasks, entered just after a rising edge
  // --------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    req.paddr <= a;
    req.pwrite <= wr;
    req.pwdata <= {24'h00_0000, wd};
    req.pstrb <= 4'hF;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr8
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask : rd_chk
  task automatic rd16();
    xfer(1'b0, ADDR_CNT_HI, 8'h00);
    v[15:8] = rd[7:0];
    xfer(1'b0, ADDR_CNT_LO, 8'h00);
    v[7:0] = rd[7:0];
  endtask : rd16
  task automatic ld16(input logic [15:0] p);
    wr8(ADDR_CNT_LO, p[7:0]);
    wr8(ADDR_CNT_HI, p[15:8]);
  endtask : ld16
  task automatic pulses(input int n);
    repeat (n) begin
      SRC.drive(1'b1, 4);
      SRC.drive(1'b0, 4);
    end
    repeat (6) @(posedge sys_clk);
  endtask : pulses
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    req = '0;
    reset_n = 1'b0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    wakes = 0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(ADDR_CTRL, 8'h08);
    rd_chk(ADDR_IRQ, 8'h00);
    chk({30'h0, irq, wake}, 32'h0);
    $display("test reset done");
    ld16(16'h1234);
    rd16();
    chk({16'h0, v}, 32'h1234);
    wr8(ADDR_CNT_LO, 8'h77);
    rd_chk(ADDR_CNT_LO, 8'h77);
    rd16();
    chk({16'h0, v}, 32'h1234);
    wr8(ADDR_CNT_HI, 8'h56);
    rd16();
    chk({16'h0, v}, 32'h5634);
    wr8(ADDR_CTRL, 8'hFF);
    rd_chk(ADDR_CTRL, 8'hD8);
    wr8(ADDR_CTRL, 8'h08);
    xfer(1'b0, 8'h00, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    ld16(16'hFFFC);
    wr8(ADDR_CTRL, 8'h98);
    ld16(16'hFFF0);
    repeat (16) @(posedge sys_clk);
    rd_chk(ADDR_IRQ, 8'h40);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, wakes > 0}, 32'h1);
    wr8(ADDR_IRQ, 8'h44);
    chk({31'h0, irq}, 32'h1);
    wr8(ADDR_CTRL, 8'h88);
    rd16();
    chk({31'h0, v >= 16'hFFF0 && v <= 16'hFFFA}, 32'h1);
    wr8(ADDR_IRQ, 8'h04);
    chk({31'h0, irq}, 32'h0);
    $display("test timer done");
    ld16(16'h0000);
    wr8(ADDR_CTRL, 8'h50);
    pulses(5);
    rd16();
    chk({16'h0, v}, 32'h5);
    wr8(ADDR_CTRL, 8'h58);
    pulses(3);
    rd16();
    chk({16'h0, v}, 32'h8);
    rd_chk(ADDR_CTRL, 8'h58);
    wr8(ADDR_CTRL, 8'h48);
    $display("test event done");
    ld16(16'h0000);
    SRC.drive(1'b1, 4);
    wr8(ADDR_CTRL, 8'hD8);
    SRC.drive(1'b1, 20);
    SRC.drive(1'b0, 8);
    SRC.drive(1'b1, 40);
    SRC.drive(1'b0, 8);
    rd_chk(ADDR_CTRL, 8'hC8);
    rd16();
    chk({31'h0, v >= 16'd9 && v <= 16'd11}, 32'h1);
    v2 = v;
    pulses(2);
    rd16();
    chk({16'h0, v}, {16'h0, v2});
    $display("test pulse done");
    ld16(16'h0000);
    wr8(ADDR_CTRL, 8'h98);
    repeat (40) @(posedge sys_clk);
    wr8(ADDR_CTRL, 8'h88);
    rd16();
    chk({31'h0, v >= 16'd10 && v <= 16'd11}, 32'h1);
    v2 = v;
    wr8(ADDR_CTRL, 8'h18);
    pulses(2);
    wr8(ADDR_CTRL, 8'h08);
    rd16();
    chk({16'h0, v}, {16'h0, v2});
    $display("test timer rate done");
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(ADDR_CTRL, 8'h08);
    rd16();
    chk({16'h0, v}, 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule : tec16_counter_test

// ### bench/tec16_pin_source.sv
// far-side model: a source of events and pulses on the counter's input pin
// assumes its tasks are called just after a rising edge of clk_in
`timescale 1ns/1ps
module tec16_pin_source (
  input wire logic clk_in,
  output logic pin_out
);
  initial pin_out = 1'b0;
  // sets the pin at the edge and holds it n cycles
  task automatic drive(input logic lvl, input int n);
    pin_out <= lvl;
    repeat (n) @(posedge clk_in);
  endtask : drive
endmodule : tec16_pin_source

// ### logic/tec16_counter.sv
// 16-bit timer/event counter with buffered preload, apb slave
// assumes one clock, async active-low chip reset, pin input asynchronous
//
// Contract
// - 16-bit up-counter, pin or clock divided by 4
// - low byte write fills only holding buffer
// - high byte write loads preload with buffer
// - high read latches low byte; read high first
// - two-bit mode selects event, timer or pulse
// - mode codes 01 event, 10 timer, 11 pulse
// - overflow reloads preload and sets overflow flag
// - event mode edge select 1 falling, 0 rising
// - pulse mode counts between edges, then clears run
// - finished measurement holds until run set again
// - pulse mode uses pin transitions, not levels
// - pulse mode overflow reloads and flags too
// - run bit enables counting; software stops it
// - overflow is a halt wake-up event
// - interrupt enable zero suppresses overflow service
// - preload write while stopped loads counter too
// - control bits 0 to 2 read zero
// - chip reset turns timer off, control 08h
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module tec16_counter (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire tec16_pkg::tec16_apb_req_t APB_REQ_IN,
  output tec16_pkg::tec16_apb_rsp_t APB_RSP_OUT,
  input wire logic EVENT_INPUT_PIN_IN,
  output logic OVERFLOW_IRQ_OUT,
  output logic WAKEUP_OUT
);
  import tec16_pkg::*;

  // ------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------
  tec16_state_t q;
  tec16_state_t d;

  logic [1:0] mode;
  logic run;
  logic edge_sel;
  logic rise;
  logic fall;
  logic tick;
  logic ev_edge;
  logic start_edge;
  logic stop_edge;
  logic inc;
  logic ovf;
  logic setup;
  logic access;
  logic wr;
  logic hit_hi;
  logic hit_lo;
  logic hit_ctrl;
  logic hit_irq;
  logic hit;

  assign mode = q.ctrl[CTRL_MODE_HI:CTRL_MODE_LO];
  assign run = q.ctrl[CTRL_RUN];
  assign edge_sel = q.ctrl[CTRL_EDGE];

  // edges seen only past the second sync stage
  assign rise = q.ev_s2 & ~q.ev_s3;
  assign fall = ~q.ev_s2 & q.ev_s3;
  assign tick = (q.div == DIV_LAST);
  assign ev_edge = edge_sel ? fall : rise;
  assign start_edge = edge_sel ? rise : fall;
  assign stop_edge = edge_sel ? fall : rise;

  assign inc = run & (((mode == MODE_EVENT) & ev_edge)
    | ((mode == MODE_TIMER) & tick)
    | ((mode == MODE_PULSE) & q.meas & tick));
  assign ovf = inc & (q.cnt == CNT_MAX);

  assign setup = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
  assign access = APB_REQ_IN.psel & APB_REQ_IN.penable;
  assign wr = access & APB_REQ_IN.pwrite & APB_REQ_IN.pstrb[0];
  assign hit_hi = (APB_REQ_IN.paddr == ADDR_CNT_HI);
  assign hit_lo = (APB_REQ_IN.paddr == ADDR_CNT_LO);
  assign hit_ctrl = (APB_REQ_IN.paddr == ADDR_CTRL);
  assign hit_irq = (APB_REQ_IN.paddr == ADDR_IRQ);
  assign hit = hit_hi | hit_lo | hit_ctrl | hit_irq;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.wake = 1'b0;
    d.ev_s1 = EVENT_INPUT_PIN_IN;
    d.ev_s2 = q.ev_s1;
    d.ev_s3 = q.ev_s2;
    d.div = q.div + 2'h1;

    // pulse width: arm, measure, finish
    if ((mode == MODE_PULSE) && run) begin
      if (!q.meas && start_edge) begin
        d.meas = 1'b1;
      end else if (q.meas && stop_edge) begin
        d.meas = 1'b0;
        d.ctrl[CTRL_RUN] = 1'b0;
      end
    end else begin
      d.meas = 1'b0;
    end

    // read side effects, sampled in the setup cycle
    if (setup && !APB_REQ_IN.pwrite) begin
      if (hit_hi) begin
        d.prdata = {24'h000000, q.cnt[15:8]};
        d.lbuf = q.cnt[7:0];
      end else if (hit_lo) begin
        d.prdata = {24'h000000, q.lbuf};
      end else if (hit_ctrl) begin
        d.prdata = {24'h000000, q.ctrl & CTRL_MASK};
      end else if (hit_irq) begin
        d.prdata = 32'h0000_0000;
        d.prdata[IRQ_FLAG_BIT] = q.flag;
        d.prdata[IRQ_EN_BIT] = q.ie;
      end else begin
        d.prdata = 32'h0000_0000;
      end
    end

    // counting
    if (inc) begin
      if (ovf) begin
        d.cnt = q.pre;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end

    // register writes, taken in the access cycle
    if (wr) begin
      if (hit_lo) begin
        d.lbuf = APB_REQ_IN.pwdata[7:0];
      end else if (hit_hi) begin
        d.pre = {APB_REQ_IN.pwdata[7:0], q.lbuf};
        if (!run) begin
          d.cnt = {APB_REQ_IN.pwdata[7:0], q.lbuf};
        end
      end else if (hit_ctrl) begin
        d.ctrl = APB_REQ_IN.pwdata[7:0] & CTRL_MASK;
      end else if (hit_irq) begin
        d.ie = APB_REQ_IN.pwdata[IRQ_EN_BIT];
        d.flag = APB_REQ_IN.pwdata[IRQ_FLAG_BIT];
      end
    end

    // overflow set wins over a same-cycle clear
    if (ovf) begin
      d.flag = 1'b1;
      d.wake = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign APB_RSP_OUT.prdata = q.prdata;
  assign APB_RSP_OUT.pready = 1'b1;
  assign APB_RSP_OUT.pslverr = access & ~hit;
  assign OVERFLOW_IRQ_OUT = q.flag & q.ie;
  assign WAKEUP_OUT = q.wake;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  logic wr_hi;
  logic wr_lo;
  logic rd_hi;
  logic rd_ctrl;
  assign wr_hi = wr & hit_hi;
  assign wr_lo = wr & hit_lo;
  assign rd_hi = setup & ~APB_REQ_IN.pwrite & hit_hi;
  assign rd_ctrl = setup & ~APB_REQ_IN.pwrite & hit_ctrl;

  logic rd_lo;
  logic rd_any;
  logic wr_ctrl;
  logic wr_irq;
  assign rd_lo = setup & ~APB_REQ_IN.pwrite & hit_lo;
  assign rd_any = setup & ~APB_REQ_IN.pwrite;
  assign wr_ctrl = wr & hit_ctrl;
  assign wr_irq = wr & hit_irq;

  sequence seq_meas_start;
    (mode == MODE_PULSE) && run && !q.meas && start_edge;
  endsequence

  sequence seq_wrap;
    inc && (q.cnt == CNT_MAX);
  endsequence

  sequence seq_meas_end;
    (mode == MODE_PULSE) && run && q.meas && stop_edge && !(wr && hit_ctrl);
  endsequence

  sequence seq_stopped_write;
    wr_hi && !run;
  endsequence

  chk_ovf_reload: assert property (
    seq_wrap |=> (q.flag && q.cnt == $past(q.pre)))
    else $error("overflow did not reload and flag");

  chk_lo_buffer: assert property (
    wr_lo && !wr_hi |=> $stable(q.pre) && q.lbuf == $past(APB_REQ_IN.pwdata[7:0]))
    else $error("low byte write touched preload");

  chk_hi_preload: assert property (
    wr_hi |=> q.pre == {$past(APB_REQ_IN.pwdata[7:0]), $past(q.lbuf)})
    else $error("high byte write did not load preload");

  chk_hi_read_latch: assert property (
    rd_hi |=> q.lbuf == $past(q.cnt[7:0]) && q.prdata[7:0] == $past(q.cnt[15:8]))
    else $error("high read did not latch low byte");

  chk_div_tick: assert property (
    tick |=> !tick [*3] ##1 tick)
    else $error("prescaler is not divide by four");

  chk_timer_step: assert property (
    run && mode == MODE_TIMER && !tick && !wr |=> $stable(q.cnt))
    else $error("timer counted without a tick");

  chk_event_edge: assert property (
    run && mode == MODE_EVENT && ev_edge && q.cnt != CNT_MAX && !wr_hi
      |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("event edge not counted");

  chk_meas_end: assert property (
    seq_meas_end |=> !run && !q.meas)
    else $error("measurement end did not clear run");

  chk_meas_hold: assert property (
    mode == MODE_PULSE && !run && !wr_hi |=> $stable(q.cnt))
    else $error("finished measurement changed count");

  chk_stop_load: assert property (
    seq_stopped_write |=> q.cnt == q.pre)
    else $error("stopped preload write missed counter");

  chk_irq_gate: assert property (
    !q.ie |-> !OVERFLOW_IRQ_OUT)
    else $error("interrupt not suppressed");

  chk_wake_pulse: assert property (
    seq_wrap |=> WAKEUP_OUT ##1 (!WAKEUP_OUT || $past(ovf)))
    else $error("wake-up pulse missing");

  chk_ctrl_zero: assert property (
    rd_ctrl |=> q.prdata[2:0] == 3'h0)
    else $error("unused control bits read nonzero");

  chk_run_kept: assert property (
    run && mode != MODE_PULSE && !(wr && hit_ctrl) |=> run)
    else $error("run cleared by hardware");

  // ------------------------------------------------------------
  // checks: register side
  // ------------------------------------------------------------
  chk_lo_read: assert property (
    rd_lo |=> q.prdata == {24'h000000, $past(q.lbuf)})
    else $error("low byte read did not return buffer");

  chk_read_upper: assert property (
    rd_any |=> q.prdata[31:8] == 24'h000000)
    else $error("read data upper bits nonzero");

  chk_prdata_keep: assert property (
    !rd_any |=> $stable(q.prdata))
    else $error("read data changed without a read");

  chk_lbuf_keep: assert property (
    !wr_lo && !rd_hi |=> $stable(q.lbuf))
    else $error("low byte buffer changed unasked");

  chk_pre_keep: assert property (
    !wr_hi |=> $stable(q.pre))
    else $error("preload changed without high write");

  chk_lo_cnt_keep: assert property (
    wr_lo && !inc |=> $stable(q.cnt))
    else $error("low byte write touched counter");

  chk_ctrl_write: assert property (
    wr_ctrl |=> q.ctrl == ($past(APB_REQ_IN.pwdata[7:0]) & CTRL_MASK))
    else $error("control write not taken");

  chk_ctrl_unused: assert property (
    q.ctrl[2:0] == 3'h0)
    else $error("unused control bits set");

  chk_ie_write: assert property (
    wr_irq |=> q.ie == $past(APB_REQ_IN.pwdata[IRQ_EN_BIT]))
    else $error("interrupt enable write not taken");

  // ------------------------------------------------------------
  // checks: counting, measuring, flag
  // ------------------------------------------------------------
  chk_div_step: assert property (
    1'b1 |=> q.div == 2'($past(q.div) + 2'h1))
    else $error("prescaler did not step");

  chk_timer_tick: assert property (
    run && mode == MODE_TIMER && tick && q.cnt != CNT_MAX && !wr_hi |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("timer tick not counted");

  chk_event_idle: assert property (
    run && mode == MODE_EVENT && !ev_edge && !wr_hi |=> $stable(q.cnt))
    else $error("event count moved without edge");

  chk_unused_mode: assert property (
    mode == MODE_UNUSED && !wr_hi |=> $stable(q.cnt))
    else $error("unused mode counted");

  chk_stopped_hold: assert property (
    !run && !wr_hi |=> $stable(q.cnt))
    else $error("stopped counter moved");

  chk_sync_order: assert property (
    rise |=> !rise)
    else $error("one pin edge seen twice");

  chk_meas_start: assert property (
    seq_meas_start |=> q.meas)
    else $error("start edge did not arm measurement");

  chk_meas_tick: assert property (
    mode == MODE_PULSE && run && q.meas && tick && q.cnt != CNT_MAX && !wr_hi
      |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("measurement tick not counted");

  chk_meas_idle: assert property (
    mode == MODE_PULSE && !q.meas && !wr_hi |=> $stable(q.cnt))
    else $error("pulse count moved while not measuring");

  chk_meas_gate: assert property (
    !(mode == MODE_PULSE && run) |=> !q.meas)
    else $error("measurement armed without run");

  chk_run_fall: assert property (
    $fell(run) |-> $past(wr_ctrl) || $past(q.meas && stop_edge))
    else $error("run cleared without cause");

  chk_flag_keep: assert property (
    !ovf && !wr_irq |=> $stable(q.flag))
    else $error("overflow flag changed unasked");

  chk_flag_write: assert property (
    wr_irq && !ovf |=> q.flag == $past(APB_REQ_IN.pwdata[IRQ_FLAG_BIT]))
    else $error("overflow flag write not taken");

  chk_irq_level: assert property (
    q.flag && q.ie |-> OVERFLOW_IRQ_OUT)
    else $error("enabled overflow not signalled");

  chk_wake_cause: assert property (
    WAKEUP_OUT |-> $past(ovf))
    else $error("wake-up without overflow");

endmodule : tec16_counter

// ### logic/tec16_pkg.sv
// constants, carriers and state layout of the 16-bit timer/event counter
// assumes an apb master on the same clock as the counter
package tec16_pkg;

  // --------------------------------------------------------------
  // bus and register map
  // --------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] IDX_CNT_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] IDX_CNT_LO = 8'h0D;
  localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h0E;
  localparam logic [ADDR_W-1:0] IDX_IRQ = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = {IDX_CNT_HI[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = {IDX_CNT_LO[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ = {IDX_IRQ[ADDR_W-3:0], 2'h0};

  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int unsigned CTRL_EDGE = 3;
  localparam int unsigned CTRL_RUN = 4;
  localparam int unsigned CTRL_MODE_LO = 6;
  localparam int unsigned CTRL_MODE_HI = 7;
  localparam logic [7:0] CTRL_MASK = 8'hD8;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam int unsigned IRQ_EN_BIT = 2;
  localparam int unsigned IRQ_FLAG_BIT = 6;

  // --------------------------------------------------------------
  // modes and counts
  // --------------------------------------------------------------
  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [3:0] pstrb;
    logic [DATA_W-1:0] pwdata;
  } tec16_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } tec16_apb_rsp_t;

  typedef struct packed {
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic [1:0] div;
    logic [15:0] cnt;
    logic [15:0] pre;
    logic [7:0] lbuf;
    logic [7:0] ctrl;
    logic flag;
    logic ie;
    logic meas;
    logic wake;
    logic [DATA_W-1:0] prdata;
  } tec16_state_t;

  localparam tec16_state_t STATE_RESET = '{
    ev_s1: 1'b0, ev_s2: 1'b0, ev_s3: 1'b0, div: 2'h0,
    cnt: CNT_RESET, pre: CNT_RESET, lbuf: 8'h00, ctrl: CTRL_RESET,
    flag: 1'b0, ie: 1'b0, meas: 1'b0, wake: 1'b0, prdata: 32'h0000_0000
  };

endpackage : tec16_pkg
